// File: core/keypad_menu_pkg.sv
// package for the keypad parameter menu: register map, reset values, timing, states
// assumes a 100 MHz clock and a classic wishbone slave port
package keypad_menu_pkg;
  localparam int VAL_W = 16;
  // register byte offsets
  localparam logic [7:0] ADDR_STATUS      = 8'h00;
  localparam logic [7:0] ADDR_PASSWORD    = 8'h04;
  localparam logic [7:0] ADDR_DAMPING     = 8'h08;
  localparam logic [7:0] ADDR_RANGE_START = 8'h0C;
  localparam logic [7:0] ADDR_RANGE_END   = 8'h10;
  localparam logic [7:0] ADDR_ZERO_WINDOW = 8'h14;
  localparam logic [7:0] ADDR_OFFSET      = 8'h18;
  localparam logic [7:0] ADDR_BASIC_LO    = 8'h1C;
  localparam logic [7:0] ADDR_BASIC_HI    = 8'h20;
  localparam logic [7:0] ADDR_UNIT        = 8'h24;
  localparam logic [7:0] ADDR_OUTPUT      = 8'h28;
  localparam logic [7:0] ADDR_DISPLAY     = 8'h2C;
  // status field positions
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_ITEM_LSB  = 4;
  // values after reset
  localparam logic [9:0]  RST_PASSWORD    = 10'h000;
  localparam logic [9:0]  RST_DAMPING     = 10'h000;
  localparam logic [15:0] RST_BASIC_LO    = 16'h0000;
  localparam logic [15:0] RST_BASIC_HI    = 16'h0190;
  localparam logic [15:0] RST_RANGE_START = 16'h0000;
  localparam logic [15:0] RST_RANGE_END   = 16'h0190;
  localparam logic [15:0] RST_ZERO_WINDOW = 16'h0000;
  localparam logic [15:0] RST_OFFSET      = 16'h0000;
  localparam logic [3:0]  RST_UNIT        = 4'h0;
  // limits
  localparam logic [9:0]  DAMP_MAX     = 10'h3E8;
  localparam logic [9:0]  PASSWORD_MAX = 10'h3E7;
  localparam int          SPREAD_MAX   = 4;
  localparam int          OFFSET_DIV   = 3;
  localparam int          DAMP_SHIFT   = 3;
  localparam logic [15:0] OUT_FULL     = 16'hFFFF;
  // timing
  localparam longint CLK_HZ          = 100_000_000;
  localparam longint TIMEOUT_S       = 60;
  localparam longint TIMEOUT_CYCLES  = TIMEOUT_S * CLK_HZ;
  localparam longint NOTE_MS         = 2000;
  localparam longint NOTE_CYCLES     = NOTE_MS * CLK_HZ / 1000;
  localparam longint DAMP_UNIT_MS    = 100;
  localparam longint DAMP_TICK_CYCLES = DAMP_UNIT_MS * CLK_HZ / 1000 / (1 << DAMP_SHIFT);

  typedef enum logic [2:0] {
    ST_NORMAL   = 3'b000,
    ST_PASSWORD = 3'b001,
    ST_MENU     = 3'b010,
    ST_EDIT     = 3'b011,
    ST_TIMEOUT  = 3'b100,
    ST_ERROR    = 3'b101
  } state_type;

  typedef enum logic [2:0] {
    ITEM_EXIT        = 3'b000,
    ITEM_DAMPING     = 3'b001,
    ITEM_RANGE_START = 3'b010,
    ITEM_RANGE_END   = 3'b011,
    ITEM_ZERO_WINDOW = 3'b100,
    ITEM_OFFSET      = 3'b101
  } item_type;
  localparam item_type ITEM_LAST = ITEM_OFFSET;
endpackage

// File: core/keypad_parameter_menu.sv
// key driven parameter menu with damping, range mapping and zero window
// assumes one-cycle key press pulses synchronous to clk_i and a wishbone master
// Operation
// - show measured value, bar graph and unit
// - enter in normal mode opens menu at exit
// - up advances, down steps back to exit
// - exit entry at both ends leaves menu
// - enter edits, keys change, enter stores
// - one minute idle returns, shows timeout, discards
// - wrong password returns straight to readout
// - zero password skips the query
// - damping zero to hundred seconds sets response
// - damping filters display and output only
// - range start maps to 4 mA end
// - range end maps to 20 mA end
// - start below end gives rising output
// - end below start gives falling output
// - user range at most four times narrower
// - bad spread shows error, keeps old value
// - values inside zero window display as zero
// - zero window off inside the menu
// - offset edit starts from present measured value
// - offset limited to one third of range
`timescale 1ns/1ps
`default_nettype none
module keypad_parameter_menu
  import keypad_menu_pkg::*;
#(
  parameter longint TIMEOUT_CYC   = TIMEOUT_CYCLES,
  parameter longint NOTE_CYC      = NOTE_CYCLES,
  parameter longint DAMP_TICK_CYC = DAMP_TICK_CYCLES
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [7:0]        adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  // keys
  input  wire logic              key_down_i,
  input  wire logic              key_enter_i,
  input  wire logic              key_up_i,
  // measurement
  input  wire logic [VAL_W-1:0]  meas_i,
  // display and output
  output logic      [2:0]        disp_mode_o,
  output logic      [2:0]        disp_item_o,
  output logic      [VAL_W-1:0]  disp_value_o,
  output logic      [3:0]        disp_unit_o,
  output logic      [3:0]        bar_level_o,
  output logic      [15:0]       out_level_o,
  output logic      [VAL_W-1:0]  raw_value_o
);

  state_type state_reg;
  item_type  item_reg;
  logic        [9:0]       password_reg;
  logic        [9:0]       damping_reg;
  logic signed [VAL_W-1:0] range_start_reg;
  logic signed [VAL_W-1:0] range_end_reg;
  logic signed [VAL_W-1:0] zero_window_reg;
  logic signed [VAL_W-1:0] offset_reg;
  logic signed [VAL_W-1:0] basic_lo_reg;
  logic signed [VAL_W-1:0] basic_hi_reg;
  logic        [3:0]       unit_reg;
  logic signed [VAL_W-1:0] edit_reg;
  logic        [35:0]      timer_reg;
  logic        [35:0]      note_reg;
  logic        [31:0]      tick_reg;
  logic signed [VAL_W-1:0] damp_reg;
  logic                    ack_reg;

  logic                    key_any;
  logic                    menu_active;
  logic                    bus_wr;
  logic signed [VAL_W:0]   span;
  logic signed [VAL_W:0]   third;
  logic signed [VAL_W-1:0] edit_lo;
  logic signed [VAL_W-1:0] edit_hi;
  logic signed [VAL_W-1:0] corrected;
  logic signed [VAL_W:0]   pair_diff;
  logic                    spread_ok;
  logic                    save_range;
  logic                    timed_out;
  logic signed [VAL_W-1:0] edit_step;

  assign key_any     = key_down_i | key_enter_i | key_up_i;
  assign menu_active = (state_reg == ST_PASSWORD) || (state_reg == ST_MENU) ||
                       (state_reg == ST_EDIT) || (state_reg == ST_ERROR);
  assign bus_wr      = cyc_i & stb_i & we_i & ~ack_reg;
  assign span        = (VAL_W+1)'(basic_hi_reg) - (VAL_W+1)'(basic_lo_reg);
  assign third       = span / (VAL_W+1)'(OFFSET_DIV);
  assign corrected   = VAL_W'($signed(meas_i) + offset_reg);
  assign timed_out   = menu_active && !key_any && (timer_reg >= 36'(TIMEOUT_CYC - 1));

  // spread check on the pair that would result from saving
  always_comb begin
    if (item_reg == ITEM_RANGE_START) begin
      pair_diff = (VAL_W+1)'(range_end_reg) - (VAL_W+1)'(edit_reg);
    end else begin
      pair_diff = (VAL_W+1)'(edit_reg) - (VAL_W+1)'(range_start_reg);
    end
    if (pair_diff < 0) begin
      pair_diff = -pair_diff;
    end
    spread_ok  = (pair_diff * SPREAD_MAX) >= span;
    save_range = (state_reg == ST_EDIT) && key_enter_i &&
                 ((item_reg == ITEM_RANGE_START) || (item_reg == ITEM_RANGE_END));
  end

  // edit limits per entry
  always_comb begin
    case (state_reg == ST_PASSWORD ? ITEM_EXIT : item_reg)
      ITEM_DAMPING: begin
        edit_lo = '0;
        edit_hi = VAL_W'(DAMP_MAX);
      end
      ITEM_RANGE_START, ITEM_RANGE_END: begin
        edit_lo = basic_lo_reg;
        edit_hi = basic_hi_reg;
      end
      ITEM_ZERO_WINDOW: begin
        edit_lo = '0;
        edit_hi = VAL_W'(span);
      end
      ITEM_OFFSET: begin
        edit_lo = VAL_W'(-third);
        edit_hi = VAL_W'(third);
      end
      default: begin
        edit_lo = '0;
        edit_hi = VAL_W'(PASSWORD_MAX);
      end
    endcase
  end

  function automatic logic signed [VAL_W-1:0] step_value(input logic signed [VAL_W-1:0] v,
                                                         input logic up,
                                                         input logic down,
                                                         input logic signed [VAL_W-1:0] lo,
                                                         input logic signed [VAL_W-1:0] hi);
    logic signed [VAL_W-1:0] r;
    r = v;
    if (up && v < hi) begin
      r = v + VAL_W'(1);
    end else if (down && v > lo) begin
      r = v - VAL_W'(1);
    end
    return r;
  endfunction

  assign edit_step = step_value(edit_reg, key_up_i, key_down_i, edit_lo, edit_hi);

  // menu state machine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_NORMAL;
      item_reg  <= ITEM_EXIT;
    end else if (timed_out) begin
      state_reg <= ST_TIMEOUT;
    end else begin
      case (state_reg)
        ST_NORMAL: begin
          if (key_enter_i) begin
            item_reg  <= ITEM_EXIT;
            state_reg <= (password_reg == RST_PASSWORD) ? ST_MENU : ST_PASSWORD;
          end
        end
        ST_PASSWORD: begin
          if (key_enter_i) begin
            state_reg <= (edit_reg == VAL_W'(password_reg)) ? ST_MENU : ST_NORMAL;
          end
        end
        ST_MENU: begin
          if (key_enter_i) begin
            state_reg <= (item_reg == ITEM_EXIT) ? ST_NORMAL : ST_EDIT;
          end else if (key_up_i) begin
            item_reg <= (item_reg == ITEM_LAST) ? ITEM_EXIT : item_type'(item_reg + 3'h1);
          end else if (key_down_i && item_reg != ITEM_EXIT) begin
            item_reg <= item_type'(item_reg - 3'h1);
          end
        end
        ST_EDIT: begin
          if (key_enter_i) begin
            state_reg <= (save_range && !spread_ok) ? ST_ERROR : ST_MENU;
          end
        end
        ST_TIMEOUT, ST_ERROR: begin
          if (note_reg >= 36'(NOTE_CYC - 1)) begin
            state_reg <= (state_reg == ST_ERROR) ? ST_MENU : ST_NORMAL;
          end
        end
        default: begin
          state_reg <= ST_NORMAL;
        end
      endcase
    end
  end

  // edit buffer, cleared on opening the menu, loaded on opening an entry, kept on leaving
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      edit_reg <= '0;
    end else if (state_reg == ST_NORMAL && key_enter_i) begin
      edit_reg <= '0;
    end else if (state_reg == ST_MENU && key_enter_i) begin
      case (item_reg)
        ITEM_DAMPING:     edit_reg <= VAL_W'(damping_reg);
        ITEM_RANGE_START: edit_reg <= range_start_reg;
        ITEM_RANGE_END:   edit_reg <= range_end_reg;
        ITEM_ZERO_WINDOW: edit_reg <= zero_window_reg;
        ITEM_OFFSET:      edit_reg <= offset_reg;
        default:          edit_reg <= '0;
      endcase
    end else if ((state_reg == ST_EDIT || state_reg == ST_PASSWORD) && !key_enter_i) begin
      edit_reg <= edit_step;
    end
  end

  // idle timer and note timer
  always_ff @(posedge clk_i) begin
    if (rst_i || !menu_active || key_any) begin
      timer_reg <= '0;
    end else begin
      timer_reg <= timer_reg + 36'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || (state_reg != ST_TIMEOUT && state_reg != ST_ERROR)) begin
      note_reg <= '0;
    end else begin
      note_reg <= note_reg + 36'h1;
    end
  end

  // parameter store: menu saves and bus writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      password_reg    <= RST_PASSWORD;
      damping_reg     <= RST_DAMPING;
      range_start_reg <= RST_RANGE_START;
      range_end_reg   <= RST_RANGE_END;
      zero_window_reg <= RST_ZERO_WINDOW;
      offset_reg      <= RST_OFFSET;
      basic_lo_reg    <= RST_BASIC_LO;
      basic_hi_reg    <= RST_BASIC_HI;
      unit_reg        <= RST_UNIT;
    end else if (state_reg == ST_EDIT && key_enter_i && !timed_out) begin
      case (item_reg)
        ITEM_DAMPING:     damping_reg <= edit_reg[9:0];
        ITEM_RANGE_START: if (spread_ok) range_start_reg <= edit_reg;
        ITEM_RANGE_END:   if (spread_ok) range_end_reg <= edit_reg;
        ITEM_ZERO_WINDOW: zero_window_reg <= edit_reg;
        ITEM_OFFSET:      offset_reg <= edit_reg;
        default:          unit_reg <= unit_reg;
      endcase
    end else if (bus_wr && sel_i[0]) begin
      case (adr_i)
        ADDR_PASSWORD:    password_reg <= (dat_i[9:0] > PASSWORD_MAX) ? PASSWORD_MAX : dat_i[9:0];
        ADDR_DAMPING:     damping_reg <= (dat_i[9:0] > DAMP_MAX) ? DAMP_MAX : dat_i[9:0];
        ADDR_RANGE_START: range_start_reg <= dat_i[VAL_W-1:0];
        ADDR_RANGE_END:   range_end_reg <= dat_i[VAL_W-1:0];
        ADDR_ZERO_WINDOW: zero_window_reg <= dat_i[VAL_W-1:0];
        ADDR_OFFSET:      offset_reg <= dat_i[VAL_W-1:0];
        ADDR_BASIC_LO:    basic_lo_reg <= dat_i[VAL_W-1:0];
        ADDR_BASIC_HI:    basic_hi_reg <= dat_i[VAL_W-1:0];
        ADDR_UNIT:        unit_reg <= dat_i[3:0];
        default:          unit_reg <= unit_reg;
      endcase
    end
  end

  // damping filter on the corrected value
  always_ff @(posedge clk_i) begin
    if (rst_i || damping_reg == '0 || tick_reg >= 32'(DAMP_TICK_CYC) * 32'(damping_reg) - 32'h1) begin
      tick_reg <= '0;
    end else begin
      tick_reg <= tick_reg + 32'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      damp_reg <= '0;
    end else if (damping_reg == '0) begin
      damp_reg <= corrected;
    end else if (tick_reg == '0) begin
      damp_reg <= VAL_W'(damp_reg + ((corrected - damp_reg) >>> DAMP_SHIFT));
    end
  end

  // output mapping from range start to range end
  logic signed [VAL_W+17:0] map_num;
  logic signed [VAL_W+17:0] map_den;
  logic signed [VAL_W+17:0] map_q;
  always_comb begin
    map_num = ((VAL_W+18)'(damp_reg) - (VAL_W+18)'(range_start_reg)) * (VAL_W+18)'(OUT_FULL);
    map_den = (VAL_W+18)'(range_end_reg) - (VAL_W+18)'(range_start_reg);
    map_q   = (map_den == '0) ? '0 : map_num / map_den;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_level_o <= '0;
      raw_value_o <= '0;
    end else begin
      raw_value_o <= meas_i;
      if (map_q < 0) begin
        out_level_o <= '0;
      end else if (map_q > (VAL_W+18)'(OUT_FULL)) begin
        out_level_o <= OUT_FULL;
      end else begin
        out_level_o <= map_q[15:0];
      end
    end
  end

  // display
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      disp_value_o <= '0;
    end else if (state_reg == ST_EDIT && item_reg == ITEM_OFFSET) begin
      disp_value_o <= VAL_W'($signed(meas_i) + edit_reg);
    end else if (state_reg == ST_EDIT || state_reg == ST_PASSWORD) begin
      disp_value_o <= edit_reg;
    end else if (state_reg == ST_NORMAL &&
                 damp_reg <= zero_window_reg && damp_reg >= -zero_window_reg) begin
      disp_value_o <= '0;
    end else begin
      disp_value_o <= damp_reg;
    end
  end

  assign disp_mode_o = state_reg;
  assign disp_item_o = item_reg;
  assign disp_unit_o = unit_reg;
  assign bar_level_o = out_level_o[15:12];

  // wishbone slave
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_o   <= '0;
    end else begin
      ack_reg <= cyc_i & stb_i & ~ack_reg;
      dat_o   <= '0;
      if (cyc_i && stb_i && !we_i && !ack_reg) begin
        case (adr_i)
          ADDR_STATUS:      dat_o <= 32'({item_reg, 1'b0, state_reg});
          ADDR_PASSWORD:    dat_o <= 32'(password_reg);
          ADDR_DAMPING:     dat_o <= 32'(damping_reg);
          ADDR_RANGE_START: dat_o <= 32'($unsigned(range_start_reg));
          ADDR_RANGE_END:   dat_o <= 32'($unsigned(range_end_reg));
          ADDR_ZERO_WINDOW: dat_o <= 32'($unsigned(zero_window_reg));
          ADDR_OFFSET:      dat_o <= 32'($unsigned(offset_reg));
          ADDR_BASIC_LO:    dat_o <= 32'($unsigned(basic_lo_reg));
          ADDR_BASIC_HI:    dat_o <= 32'($unsigned(basic_hi_reg));
          ADDR_UNIT:        dat_o <= 32'(unit_reg);
          ADDR_OUTPUT:      dat_o <= 32'(out_level_o);
          ADDR_DISPLAY:     dat_o <= 32'($unsigned(disp_value_o));
          default:          dat_o <= '0;
        endcase
      end
    end
  end
  assign ack_o = ack_reg;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_menu_open: assert property (state_reg == ST_NORMAL && key_enter_i && password_reg == '0
    |=> state_reg == ST_MENU && item_reg == ITEM_EXIT) else $error("enter did not open menu");
  chk_query_asked: assert property (state_reg == ST_NORMAL && key_enter_i && password_reg != '0
    |=> state_reg == ST_PASSWORD) else $error("password query skipped");
  chk_wrong_code: assert property (state_reg == ST_PASSWORD && key_enter_i && !timed_out
    && edit_reg != VAL_W'(password_reg) |=> state_reg == ST_NORMAL) else $error("wrong code granted");
  chk_up_advance: assert property (state_reg == ST_MENU && key_up_i && !key_enter_i && !timed_out
    |=> item_reg == (($past(item_reg) == ITEM_LAST) ? ITEM_EXIT : item_type'($past(item_reg) + 3'h1)))
    else $error("up did not advance");
  chk_exit_leave: assert property (state_reg == ST_MENU && key_enter_i && item_reg == ITEM_EXIT
    && !timed_out |=> state_reg == ST_NORMAL) else $error("exit did not leave");
  chk_idle_limit: assert property (menu_active |-> timer_reg < 36'(TIMEOUT_CYC))
    else $error("idle timer overran");
  chk_key_restart: assert property (menu_active && key_any |=> timer_reg == '0)
    else $error("key did not restart timer");
  chk_range_keep: assert property (save_range && !spread_ok && !timed_out
    |=> state_reg == ST_ERROR && $stable(range_start_reg) && $stable(range_end_reg))
    else $error("bad range accepted");
  chk_damp_bound: assert property (damping_reg <= DAMP_MAX)
    else $error("damping out of range");
  chk_zero_shown: assert property (state_reg == ST_NORMAL && damp_reg == '0 |=> disp_value_o == '0)
    else $error("zero not shown");
endmodule
`default_nettype wire

// File: tb/keypad_operator.sv
// operator model: presses the three keys as one-cycle pulses
// assumes the bench calls press from its main sequence, one press at a time
`timescale 1ns/1ps
`default_nettype none
module keypad_operator (
  // clock
  input  wire logic clk_i,
  // keys
  output logic      key_down_o,
  output logic      key_enter_o,
  output logic      key_up_o
);
  initial begin
    key_down_o  = 1'b0;
    key_enter_o = 1'b0;
    key_up_o    = 1'b0;
  end
  // 0 down, 1 enter, 2 up; one pulse, then the answer settles
  task automatic press(input int k);
    @(posedge clk_i);
    key_down_o  <= (k == 0);
    key_enter_o <= (k == 1);
    key_up_o    <= (k == 2);
    @(posedge clk_i);
    key_down_o  <= 1'b0;
    key_enter_o <= 1'b0;
    key_up_o    <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask
endmodule
`default_nettype wire

// File: tb/keypad_parameter_menu_tb.sv
// testbench for the keypad parameter menu
// assumes short timer parameters and a classic wishbone single-cycle master
`timescale 1ns/1ps
`default_nettype none
module keypad_parameter_menu_tb;
  import keypad_menu_pkg::*;
  logic              clk_i;
  logic              rst_i;
  logic              cyc_i;
  logic              stb_i;
  logic              we_i;
  logic [7:0]        adr_i;
  logic [3:0]        sel_i;
  logic [31:0]       dat_i;
  logic [31:0]       dat_o;
  logic              ack_o;
  logic              key_down_i;
  logic              key_enter_i;
  logic              key_up_i;
  logic [VAL_W-1:0]  meas_i;
  logic [2:0]        disp_mode_o;
  logic [2:0]        disp_item_o;
  logic [VAL_W-1:0]  disp_value_o;
  logic [3:0]        disp_unit_o;
  logic [3:0]        bar_level_o;
  logic [15:0]       out_level_o;
  logic [VAL_W-1:0]  raw_value_o;
  logic [15:0]       mid_level;
  int                mismatches;
  int                num_checks;

  keypad_parameter_menu #(.TIMEOUT_CYC(200), .NOTE_CYC(20), .DAMP_TICK_CYC(2)) i_keypad_parameter_menu (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .key_down_i(key_down_i),
    .key_enter_i(key_enter_i), .key_up_i(key_up_i), .meas_i(meas_i), .disp_mode_o(disp_mode_o),
    .disp_item_o(disp_item_o), .disp_value_o(disp_value_o), .disp_unit_o(disp_unit_o),
    .bar_level_o(bar_level_o), .out_level_o(out_level_o), .raw_value_o(raw_value_o));
  keypad_operator i_keypad_operator (
    .clk_i(clk_i), .key_down_o(key_down_i), .key_enter_o(key_enter_i), .key_up_o(key_up_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= we;
    adr_i <= adr;
    dat_i <= wd;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      print_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
    logic [31:0] rd;
    wb(1'b1, adr, wd, rd);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] rd;
    wb(1'b0, adr, 32'h0000_0000, rd);
    check(name, rd, exp);
  endtask

  task automatic wait_mode(input logic [2:0] m, input int lim);
    int n;
    n = 0;
    while (disp_mode_o !== m && n < lim) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    check("mode", {29'h0, disp_mode_o}, {29'h0, m});
    if (disp_mode_o !== m) print_verdict();
  endtask

  task automatic wait_out(input logic [15:0] v);
    int n;
    n = 0;
    while (out_level_o !== v && n < 40) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    check("out_level", {16'h0, out_level_o}, {16'h0, v});
    if (out_level_o !== v) print_verdict();
  endtask

  task automatic keys(input int k, input int times);
    repeat (times) i_keypad_operator.press(k);
  endtask

  initial begin
    mismatches = 0;
    num_checks = 0;
    rst_i  = 1'b1;
    cyc_i  = 1'b0;
    stb_i  = 1'b0;
    we_i   = 1'b0;
    adr_i  = 8'h00;
    sel_i  = 4'hF;
    dat_i  = 32'h0000_0000;
    meas_i = 16'h0000;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("status", ADDR_STATUS, 32'h0000_0000);
    rd_chk("password", ADDR_PASSWORD, 32'h0000_0000);
    rd_chk("range_end", ADDR_RANGE_END, 32'h0000_0190);
    rd_chk("unmapped", 8'h30, 32'h0000_0000);
    $display("test reset done");
    keys(1, 1);
    check("mode", {29'h0, disp_mode_o}, 32'h2);
    check("item", {29'h0, disp_item_o}, 32'h0);
    keys(0, 1);
    check("item", {29'h0, disp_item_o}, 32'h0);
    keys(2, 5);
    check("item", {29'h0, disp_item_o}, 32'h5);
    keys(2, 1);
    check("item", {29'h0, disp_item_o}, 32'h0);
    keys(2, 1);
    keys(1, 1);
    check("mode", {29'h0, disp_mode_o}, 32'h3);
    keys(2, 2);
    keys(1, 1);
    rd_chk("damping", ADDR_DAMPING, 32'h0000_0002);
    keys(0, 1);
    keys(1, 1);
    check("mode", {29'h0, disp_mode_o}, 32'h0);
    wr(ADDR_DAMPING, 32'h0000_0000);
    $display("test menu done");
    wait_out(16'h0000);
    @(posedge clk_i) meas_i <= 16'h0190;
    wait_out(16'hFFFF);
    check("display", {16'h0, disp_value_o}, 32'h0190);
    check("bar", {28'h0, bar_level_o}, 32'hF);
    check("raw", {16'h0, raw_value_o}, 32'h0190);
    @(posedge clk_i) meas_i <= 16'h00C8;
    repeat (10) @(posedge clk_i);
    #1;
    mid_level = out_level_o;
    check("rising", {31'h0, (mid_level > 16'h0000 && mid_level < 16'hFFFF)}, 32'h1);
    wr(ADDR_DAMPING, 32'h0000_0001);
    @(posedge clk_i) meas_i <= 16'h0190;
    repeat (6) @(posedge clk_i);
    #1;
    check("damped", {31'h0, (disp_value_o < 16'h0190)}, 32'h1);
    check("raw_damped", {16'h0, raw_value_o}, 32'h0190);
    wr(ADDR_DAMPING, 32'h0000_0000);
    wr(ADDR_UNIT, 32'h0000_0003);
    check("unit", {28'h0, disp_unit_o}, 32'h3);
    wr(ADDR_RANGE_START, 32'h0000_0190);
    wr(ADDR_RANGE_END, 32'h0000_0000);
    @(posedge clk_i) meas_i <= 16'h0190;
    wait_out(16'h0000);
    wr(ADDR_RANGE_START, 32'h0000_0000);
    wr(ADDR_RANGE_END, 32'h0000_0064);
    $display("test output done");
    keys(1, 1);
    keys(2, 2);
    keys(1, 1);
    keys(2, 1);
    keys(1, 1);
    check("mode", {29'h0, disp_mode_o}, 32'h5);
    wait_mode(3'h2, 40);
    rd_chk("range_start", ADDR_RANGE_START, 32'h0000_0000);
    keys(2, 3);
    keys(1, 1);
    @(posedge clk_i) meas_i <= 16'h0033;
    repeat (4) @(posedge clk_i);
    #1;
    check("offset_start", {16'h0, disp_value_o}, 32'h0033);
    keys(0, 140);
    check("offset_limit", {16'h0, disp_value_o}, 32'hFFAE);
    keys(2, 1);
    repeat (150) @(posedge clk_i);
    keys(2, 1);
    repeat (150) @(posedge clk_i);
    check("mode", {29'h0, disp_mode_o}, 32'h3);
    wait_mode(3'h4, 100);
    wait_mode(3'h0, 40);
    rd_chk("offset", ADDR_OFFSET, 32'h0000_0000);
    $display("test error and timeout done");
    wr(ADDR_ZERO_WINDOW, 32'h0000_0004);
    @(posedge clk_i) meas_i <= 16'h0003;
    repeat (10) @(posedge clk_i);
    #1;
    check("zero_window", {16'h0, disp_value_o}, 32'h0000);
    wr(ADDR_PASSWORD, 32'h0000_0005);
    keys(1, 1);
    check("mode", {29'h0, disp_mode_o}, 32'h1);
    keys(1, 1);
    check("mode", {29'h0, disp_mode_o}, 32'h0);
    keys(1, 1);
    keys(2, 5);
    keys(1, 1);
    check("mode", {29'h0, disp_mode_o}, 32'h2);
    check("window_off", {16'h0, disp_value_o}, 32'h0003);
    keys(1, 1);
    $display("test password done");
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    print_verdict();
  end
endmodule
`default_nettype wire
